// ---- design/ulpi_phy_intf_otg_ctrl_regs.sv ----
// Interface and OTG option registers of a ULPI transceiver, with their ULPI access engine.
// Assumes the link drives stp and data synchronously to link_clk_in; other inputs are
// asynchronous except the two core-side controls, which come from core_clk_in logic.
//
// Notes on behaviour
// [RULE1] Interface options: write 07h, set 08h, clear 09h
// [RULE2] Set writes ones, clear writes zeros, rest kept
// [RULE3] OTG options: write 0Ah, set 0Bh, clear 0Ch
// [RULE4] Guard bit zero: protection on, weak pull-up
// [RULE5] Unexpected high stop: weak pull-downs on data
// [RULE6] Guard bit one: protection and weak pulls off
// [RULE7] Protection detects a link no longer driving stop
// [RULE8] Link always programs pass-through bit to one
// [RULE9] Fault input never qualified by bus comparator
// [RULE10] Invert bit set: fault complement output inverted
// [RULE11] Clock keep bit powers only clock circuitry
// [RULE12] Clock keep honoured only serial and powered
// [RULE13] Serial select bit moves packets to serial
// [RULE14] Serial select clears itself on serial exit
// [RULE15] OTG layout fixed; bits 2,1 reset high
// [RULE16] Suspend bit low means low-power mode
// [RULE17] Link enables at most one alternative mode
`timescale 1ns/1ns
`default_nettype none
`include "ulpi_ctrl_defs.svh"

module ulpi_phy_intf_otg_ctrl_regs (
  input wire logic core_clk_in, // Core clock, 125 MHz
  input wire logic nrst_in, // Asynchronous reset, active low
  input wire logic link_clk_in, // ULPI interface clock
  input wire logic ulpi_stp_in, // Stop from the link
  input wire logic [7:0] ulpi_data_in, // Data from the link
  output logic [7:0] ulpi_data_out, // Data to the link
  output logic ulpi_data_oe_out, // High while driving data
  output logic ulpi_dir_out, // Bus direction, high toward the link
  output logic ulpi_nxt_out, // Next, throttles the link
  output logic stp_weak_pullup_out, // Weak pull-up on stop enabled
  output logic data_weak_pulldown_out, // Weak pull-downs on data 3:0 enabled
  input wire logic fault_pin_in, // External fault indicator pin
  input wire logic a_dev_bus_valid_cmp_in, // Internal bus valid comparator
  input wire logic phy_powered_n_lowpower_in, // Suspend control, low means low power
  input wire logic serial_mode_exit_in, // Pulse: serial mode has been left
  output logic fault_compl_out, // Fault complement output
  output logic bus_valid_out, // Selected bus valid indication
  output logic serial_mode_out, // Pins in 3-wire serial mode
  output logic clock_power_out, // Internal clock circuitry powered
  output logic ext_supply_drive_out, // External supply drive
  output logic bus_power_drive_out, // Bus power drive
  output logic bus_charge_out, // Bus charge
  output logic bus_discharge_out, // Bus discharge
  output logic minus_line_pulldown_out, // Minus-line pull-down
  output logic plus_line_pulldown_out, // Plus-line pull-down
  output logic id_line_pullup_out // ID pull-up
);

  localparam ulpi_ctrl_pkg::link_regs_t LINK_RST = '{
    phase: ulpi_ctrl_pkg::PH_IDLE,
    addr: 6'h00,
    wdata: 8'h00,
    ifc: `IFC_RESET,
    otg: `OTG_RESET,
    dir: 1'b0,
    nxt: 1'b0,
    dout: 8'h00,
    doe: 1'b0,
    float_seen: 1'b0,
    exit_seen: 1'b0
  };

  ulpi_ctrl_pkg::link_regs_t lq_q;
  ulpi_ctrl_pkg::link_regs_t lq_d;
  ulpi_ctrl_pkg::core_regs_t cq_q;
  ulpi_ctrl_pkg::core_regs_t cq_d;
  logic link_nrst;
  logic core_nrst;
  logic exit_tgl_s;
  logic exit_edge;
  logic [1:0] async_s;
  logic [15:0] opts_core;
  logic [7:0] ifc_core;
  logic [7:0] otg_core;

  // Apply a write, set or clear to a register value
  function automatic logic [7:0] apply_op(input logic [7:0] old,
                                          input logic [7:0] data,
                                          input ulpi_ctrl_pkg::reg_op_t op);
    logic [7:0] res;
    case (op)
      ulpi_ctrl_pkg::OP_WRITE: res = data;
      ulpi_ctrl_pkg::OP_SET: res = old | data; // RULE2
      ulpi_ctrl_pkg::OP_CLEAR: res = old & ~data; // RULE2
      default: res = old;
    endcase
    return res;
  endfunction : apply_op

  // Read decode; each register answers on all three of its addresses
  function automatic logic [7:0] read_val(input logic [5:0] addr,
                                          input logic [7:0] ifc,
                                          input logic [7:0] otg);
    logic [7:0] res;
    case (addr)
      `IFC_WR_ADDR, `IFC_SET_ADDR, `IFC_CLR_ADDR: res = ifc; // RULE1
      `OTG_WR_ADDR, `OTG_SET_ADDR, `OTG_CLR_ADDR: res = otg; // RULE3
      default: res = `UNMAPPED_READ;
    endcase
    return res;
  endfunction : read_val

  // Reset release synchronised to each domain; assertion stays asynchronous
  cdc_sync2 #(.WIDTH(1)) u_link_rst (
    .clk_in(link_clk_in),
    .nrst_in(nrst_in),
    .d_in(1'b1),
    .q_out(link_nrst)
  );

  cdc_sync2 #(.WIDTH(1)) u_core_rst (
    .clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .d_in(1'b1),
    .q_out(core_nrst)
  );

  // Serial exit event travels as a toggle into the link domain
  cdc_sync2 #(.WIDTH(1)) u_exit_sync (
    .clk_in(link_clk_in),
    .nrst_in(link_nrst),
    .d_in(cq_q.exit_tgl),
    .q_out(exit_tgl_s)
  );

  // Pin inputs from outside any clock domain
  cdc_sync2 #(.WIDTH(2)) u_pin_sync (
    .clk_in(core_clk_in),
    .nrst_in(core_nrst),
    .d_in({fault_pin_in, a_dev_bus_valid_cmp_in}),
    .q_out(async_s)
  );

  // Register contents carried to the core domain as one word
  cdc_word #(.WIDTH(16), .RST({`IFC_RESET, `OTG_RESET})) u_opts_xfer (
    .src_clk_in(link_clk_in),
    .src_nrst_in(link_nrst),
    .src_data_in({lq_q.ifc, lq_q.otg}),
    .dst_clk_in(core_clk_in),
    .dst_nrst_in(core_nrst),
    .dst_data_out(opts_core)
  );

  assign ifc_core = opts_core[15:8];
  assign otg_core = opts_core[7:0];
  assign exit_edge = exit_tgl_s ^ lq_q.exit_seen;

  // ULPI register access engine, protection detector and self-clearing serial select
  always_comb
  begin
    lq_d = lq_q;
    lq_d.exit_seen = exit_tgl_s;
    if (exit_edge)
    begin
      lq_d.ifc[`THREE_WIRE_SERIAL_SEL_BIT] = 1'b0; // RULE14
    end
    case (lq_q.phase)
      ulpi_ctrl_pkg::PH_IDLE:
      begin
        if (ulpi_stp_in)
        begin
          // Stop high with no transfer open: link has let it float
          lq_d.float_seen = 1'b1; // RULE7
        end
        else
        begin
          lq_d.float_seen = 1'b0;
          lq_d.addr = ulpi_data_in[5:0];
          if (ulpi_data_in[7:6] == `CMD_REG_WRITE)
          begin
            lq_d.phase = ulpi_ctrl_pkg::PH_WR_CMD;
          end
          else if (ulpi_data_in[7:6] == `CMD_REG_READ)
          begin
            lq_d.phase = ulpi_ctrl_pkg::PH_RD_CMD;
          end
        end
      end
      ulpi_ctrl_pkg::PH_WR_CMD:
      begin
        lq_d.phase = ulpi_ctrl_pkg::PH_WR_DATA;
      end
      ulpi_ctrl_pkg::PH_WR_DATA:
      begin
        lq_d.wdata = ulpi_data_in;
        lq_d.phase = ulpi_ctrl_pkg::PH_WR_STOP;
      end
      ulpi_ctrl_pkg::PH_WR_STOP:
      begin
        lq_d.phase = ulpi_ctrl_pkg::PH_IDLE;
        // Commit only on a proper stop; a write lands after the self-clear, so it wins
        if (ulpi_stp_in)
        begin
          case (lq_q.addr)
            `IFC_WR_ADDR: lq_d.ifc = apply_op(lq_d.ifc, lq_q.wdata & `IFC_IMPL_MASK,
                                               ulpi_ctrl_pkg::OP_WRITE); // RULE1
            `IFC_SET_ADDR: lq_d.ifc = apply_op(lq_d.ifc, lq_q.wdata & `IFC_IMPL_MASK,
                                                ulpi_ctrl_pkg::OP_SET); // RULE1
            `IFC_CLR_ADDR: lq_d.ifc = apply_op(lq_d.ifc, lq_q.wdata & `IFC_IMPL_MASK,
                                                ulpi_ctrl_pkg::OP_CLEAR); // RULE1
            `OTG_WR_ADDR: lq_d.otg = apply_op(lq_q.otg, lq_q.wdata,
                                               ulpi_ctrl_pkg::OP_WRITE); // RULE3
            `OTG_SET_ADDR: lq_d.otg = apply_op(lq_q.otg, lq_q.wdata,
                                                ulpi_ctrl_pkg::OP_SET); // RULE3
            `OTG_CLR_ADDR: lq_d.otg = apply_op(lq_q.otg, lq_q.wdata,
                                                ulpi_ctrl_pkg::OP_CLEAR); // RULE3
            default: lq_d.otg = lq_q.otg;
          endcase
        end
      end
      ulpi_ctrl_pkg::PH_RD_CMD:
      begin
        lq_d.phase = ulpi_ctrl_pkg::PH_RD_TURN;
      end
      ulpi_ctrl_pkg::PH_RD_TURN:
      begin
        lq_d.phase = ulpi_ctrl_pkg::PH_RD_DATA;
      end
      ulpi_ctrl_pkg::PH_RD_DATA:
      begin
        lq_d.phase = ulpi_ctrl_pkg::PH_RD_BACK;
      end
      ulpi_ctrl_pkg::PH_RD_BACK:
      begin
        lq_d.phase = ulpi_ctrl_pkg::PH_IDLE;
      end
      default:
      begin
        lq_d.phase = ulpi_ctrl_pkg::PH_IDLE;
      end
    endcase
    // Pin outputs follow the next phase so they leave flops
    lq_d.nxt = (lq_d.phase == ulpi_ctrl_pkg::PH_WR_CMD) ||
               (lq_d.phase == ulpi_ctrl_pkg::PH_WR_DATA) ||
               (lq_d.phase == ulpi_ctrl_pkg::PH_RD_CMD);
    lq_d.dir = (lq_d.phase == ulpi_ctrl_pkg::PH_RD_TURN) ||
               (lq_d.phase == ulpi_ctrl_pkg::PH_RD_DATA);
    lq_d.doe = (lq_d.phase == ulpi_ctrl_pkg::PH_RD_DATA);
    lq_d.dout = lq_d.doe ? read_val(lq_q.addr, lq_q.ifc, lq_q.otg) : 8'h00;
  end

  always_ff @(posedge link_clk_in or negedge link_nrst)
  begin
    if (!link_nrst)
    begin
      lq_q <= LINK_RST;
    end
    else
    begin
      lq_q <= lq_d;
    end
  end

  assign ulpi_data_out = lq_q.dout;
  assign ulpi_data_oe_out = lq_q.doe;
  assign ulpi_dir_out = lq_q.dir;
  assign ulpi_nxt_out = lq_q.nxt;
  // Weak pulls exist only while the guard is on
  assign stp_weak_pullup_out = ~lq_q.ifc[`PIN_GUARD_OFF_BIT]; // RULE4 RULE6
  assign data_weak_pulldown_out = ~lq_q.ifc[`PIN_GUARD_OFF_BIT] & lq_q.float_seen; // RULE5

  // Core-side effects of the options
  always_comb
  begin
    cq_d = cq_q;
    cq_d.exit_tgl = cq_q.exit_tgl ^ serial_mode_exit_in;
    // Pass-through bit is not looked at; only the set value is supported
    cq_d.fault_compl = async_s[1] ^ ifc_core[`FAULT_INVERT_BIT]; // RULE10 RULE8
    // Fault and comparator are alternatives, never combined
    cq_d.bus_valid = otg_core[`EXT_BUS_INDICATOR_SEL_BIT] ? cq_d.fault_compl
                                                          : async_s[0]; // RULE9
    if (!phy_powered_n_lowpower_in)
    begin
      cq_d.clk_pwr = 1'b0; // RULE16
    end
    else if (ifc_core[`THREE_WIRE_SERIAL_SEL_BIT])
    begin
      cq_d.clk_pwr = ifc_core[`SERIAL_MODE_CLOCK_KEEP_BIT]; // RULE11 RULE12
    end
    else
    begin
      cq_d.clk_pwr = 1'b1; // RULE12
    end
  end

  always_ff @(posedge core_clk_in or negedge core_nrst)
  begin
    if (!core_nrst)
    begin
      cq_q <= '{exit_tgl: 1'b0, fault_compl: 1'b0, bus_valid: 1'b0, clk_pwr: 1'b1};
    end
    else
    begin
      cq_q <= cq_d;
    end
  end

  assign fault_compl_out = cq_q.fault_compl;
  assign bus_valid_out = cq_q.bus_valid;
  assign clock_power_out = cq_q.clk_pwr;
  assign serial_mode_out = ifc_core[`THREE_WIRE_SERIAL_SEL_BIT]; // RULE13
  // OTG option outputs, layout bit 6 down to 0
  assign ext_supply_drive_out = otg_core[`EXT_SUPPLY_DRIVE_BIT]; // RULE15
  assign bus_power_drive_out = otg_core[`BUS_POWER_DRIVE_BIT];
  assign bus_charge_out = otg_core[`BUS_CHARGE_BIT];
  assign bus_discharge_out = otg_core[`BUS_DISCHARGE_BIT];
  assign minus_line_pulldown_out = otg_core[`MINUS_LINE_PULLDOWN_BIT];
  assign plus_line_pulldown_out = otg_core[`PLUS_LINE_PULLDOWN_BIT];
  assign id_line_pullup_out = otg_core[`ID_LINE_PULLUP_BIT];

  // Link-domain checks
  chk_ifc_write: assert property (@(posedge link_clk_in) disable iff (!link_nrst) // RULE1
    (lq_q.phase == ulpi_ctrl_pkg::PH_WR_STOP && ulpi_stp_in && lq_q.addr == `IFC_WR_ADDR)
    |=> (lq_q.ifc == ($past(lq_q.wdata) & `IFC_IMPL_MASK)))
    else $error("interface options write not stored");

  chk_ifc_set: assert property (@(posedge link_clk_in) disable iff (!link_nrst) // RULE2
    (lq_q.phase == ulpi_ctrl_pkg::PH_WR_STOP && ulpi_stp_in && lq_q.addr == `IFC_SET_ADDR)
    |=> ((lq_q.ifc & $past(lq_q.wdata) & `IFC_IMPL_MASK) ==
         ($past(lq_q.wdata) & `IFC_IMPL_MASK)))
    else $error("interface options set left a bit low");

  chk_otg_clear: assert property (@(posedge link_clk_in) disable iff (!link_nrst) // RULE2
    (lq_q.phase == ulpi_ctrl_pkg::PH_WR_STOP && ulpi_stp_in && lq_q.addr == `OTG_CLR_ADDR)
    |=> ((lq_q.otg & $past(lq_q.wdata)) == 8'h00) &&
        ((lq_q.otg & ~$past(lq_q.wdata)) == ($past(lq_q.otg) & ~$past(lq_q.wdata))))
    else $error("OTG options clear wrong");

  chk_otg_write: assert property (@(posedge link_clk_in) disable iff (!link_nrst) // RULE3
    (lq_q.phase == ulpi_ctrl_pkg::PH_WR_STOP && ulpi_stp_in && lq_q.addr == `OTG_WR_ADDR)
    |=> (lq_q.otg == $past(lq_q.wdata)))
    else $error("OTG options write not stored");

  chk_guard_pulls: assert property (@(posedge link_clk_in) disable iff (!link_nrst) // RULE5
    (lq_q.phase == ulpi_ctrl_pkg::PH_IDLE && ulpi_stp_in && !lq_q.ifc[`PIN_GUARD_OFF_BIT])
    ##1 !lq_q.ifc[`PIN_GUARD_OFF_BIT] |-> data_weak_pulldown_out && stp_weak_pullup_out)
    else $error("floating stop did not engage pull-downs");

  chk_guard_off: assert property (@(posedge link_clk_in) disable iff (!link_nrst) // RULE6
    lq_q.ifc[`PIN_GUARD_OFF_BIT] |-> !data_weak_pulldown_out && !stp_weak_pullup_out)
    else $error("weak pulls present with guard off");

  chk_serial_selfclr: assert property (@(posedge link_clk_in) disable iff (!link_nrst) // RULE14
    (exit_edge && lq_q.phase != ulpi_ctrl_pkg::PH_WR_STOP)
    |=> !lq_q.ifc[`THREE_WIRE_SERIAL_SEL_BIT])
    else $error("serial select not cleared on exit");

  chk_read_answer: assert property (@(posedge link_clk_in) disable iff (!link_nrst) // RULE1
    (lq_q.phase == ulpi_ctrl_pkg::PH_RD_CMD && ulpi_nxt_out)
    |=> (ulpi_dir_out && !ulpi_data_oe_out)
    ##1 (ulpi_dir_out && ulpi_data_oe_out &&
         ulpi_data_out == read_val(lq_q.addr, $past(lq_q.ifc), $past(lq_q.otg)))
    ##1 !ulpi_dir_out)
    else $error("register read answer wrong");

  // Core-domain checks
  chk_clock_lowpower: assert property (@(posedge core_clk_in) disable iff (!core_nrst) // RULE16
    (!phy_powered_n_lowpower_in ##1 !phy_powered_n_lowpower_in) |-> !clock_power_out)
    else $error("clock powered in low-power mode");

  chk_clock_normal: assert property (@(posedge core_clk_in) disable iff (!core_nrst) // RULE12
    (phy_powered_n_lowpower_in && !ifc_core[`THREE_WIRE_SERIAL_SEL_BIT]) |=> clock_power_out)
    else $error("clock unpowered outside serial mode");

  chk_fault_invert: assert property (@(posedge core_clk_in) disable iff (!core_nrst) // RULE10
    $stable(async_s[1]) && $stable(ifc_core[`FAULT_INVERT_BIT])
    |-> fault_compl_out == (async_s[1] ^ ifc_core[`FAULT_INVERT_BIT]))
    else $error("fault complement polarity wrong");

  cov_reg_write: cover property (@(posedge link_clk_in) disable iff (!link_nrst)
    lq_q.phase == ulpi_ctrl_pkg::PH_WR_STOP && ulpi_stp_in);
  cov_reg_read: cover property (@(posedge link_clk_in) disable iff (!link_nrst)
    lq_q.phase == ulpi_ctrl_pkg::PH_RD_DATA);
  cov_float_guard: cover property (@(posedge link_clk_in) disable iff (!link_nrst)
    data_weak_pulldown_out);
  cov_serial_exit: cover property (@(posedge link_clk_in) disable iff (!link_nrst)
    exit_edge && lq_q.ifc[`THREE_WIRE_SERIAL_SEL_BIT]);

endmodule : ulpi_phy_intf_otg_ctrl_regs

`default_nettype wire

// ---- design/ulpi_ctrl_defs.svh ----
// Offsets, field positions and reset values of the interface and OTG option registers.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef ULPI_CTRL_DEFS_SVH
`define ULPI_CTRL_DEFS_SVH

// Register addresses on the ULPI bus (6-bit address field of a command)
`define IFC_WR_ADDR 6'h07
`define IFC_SET_ADDR 6'h08
`define IFC_CLR_ADDR 6'h09
`define OTG_WR_ADDR 6'h0A
`define OTG_SET_ADDR 6'h0B
`define OTG_CLR_ADDR 6'h0C

// Command prefix in data bits 7:6
`define CMD_REG_WRITE 2'h2
`define CMD_REG_READ 2'h3

// Interface options fields
`define PIN_GUARD_OFF_BIT 7
`define FAULT_PASS_THROUGH_BIT 6
`define FAULT_INVERT_BIT 5
`define SERIAL_MODE_CLOCK_KEEP_BIT 3
`define THREE_WIRE_SERIAL_SEL_BIT 1
`define IFC_IMPL_MASK 8'hEA
`define IFC_RESET 8'h00

// OTG options fields, bit 7 down to bit 0
`define EXT_BUS_INDICATOR_SEL_BIT 7
`define EXT_SUPPLY_DRIVE_BIT 6
`define BUS_POWER_DRIVE_BIT 5
`define BUS_CHARGE_BIT 4
`define BUS_DISCHARGE_BIT 3
`define MINUS_LINE_PULLDOWN_BIT 2
`define PLUS_LINE_PULLDOWN_BIT 1
`define ID_LINE_PULLUP_BIT 0
`define OTG_RESET 8'h06

// Value returned for an unmapped read
`define UNMAPPED_READ 8'h00

`endif

// ---- design/ulpi_ctrl_pkg.sv ----
// Types shared by the option register block.
// Assumes the constants header is compiled alongside.
package ulpi_ctrl_pkg;

  // Phase of the ULPI register access engine
  typedef enum logic [2:0]
  {
    PH_IDLE,
    PH_WR_CMD,
    PH_WR_DATA,
    PH_WR_STOP,
    PH_RD_CMD,
    PH_RD_TURN,
    PH_RD_DATA,
    PH_RD_BACK
  } link_phase_t;

  // Kind of register update
  typedef enum logic [1:0]
  {
    OP_WRITE,
    OP_SET,
    OP_CLEAR
  } reg_op_t;

  // Link-domain state
  typedef struct packed {
    link_phase_t phase;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] ifc;
    logic [7:0] otg;
    logic dir;
    logic nxt;
    logic [7:0] dout;
    logic doe;
    logic float_seen;
    logic exit_seen;
  } link_regs_t;

  // Core-domain state
  typedef struct packed {
    logic exit_tgl;
    logic fault_compl;
    logic bus_valid;
    logic clk_pwr;
  } core_regs_t;

endpackage : ulpi_ctrl_pkg

// ---- design/cdc_sync2.sv ----
// Two-flop level synchroniser, one per bit.
// Assumes each input bit is a level that stays put for several destination cycles.
`timescale 1ns/1ns
`default_nettype none

module cdc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in, // Destination clock
  input wire logic nrst_in, // Asynchronous reset, active low
  input wire logic [WIDTH-1:0] d_in, // Asynchronous levels
  output logic [WIDTH-1:0] q_out // Synchronised levels
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_regs_t;

  sync_regs_t r_q;
  sync_regs_t r_d;

  // First stage feeds only the second
  always_comb
  begin
    r_d.s1 = d_in;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      r_q <= '0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign q_out = r_q.s2;

endmodule : cdc_sync2

`default_nettype wire

// ---- design/cdc_word.sv ----
// Toggle handshake carrying a word from one clock domain to another.
// Assumes the source word changes slowly; intermediate values may be skipped, the last one lands.
`timescale 1ns/1ns
`default_nettype none

module cdc_word #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RST = '0
) (
  input wire logic src_clk_in, // Source clock
  input wire logic src_nrst_in, // Source reset, active low
  input wire logic [WIDTH-1:0] src_data_in, // Word to carry
  input wire logic dst_clk_in, // Destination clock
  input wire logic dst_nrst_in, // Destination reset, active low
  output logic [WIDTH-1:0] dst_data_out // Carried word, registered
);

  typedef struct packed {
    logic [WIDTH-1:0] data;
    logic req;
  } src_regs_t;

  typedef struct packed {
    logic [WIDTH-1:0] data;
    logic ack;
  } dst_regs_t;

  src_regs_t s_q;
  src_regs_t s_d;
  dst_regs_t d_q;
  dst_regs_t d_d;
  logic ack_s;
  logic req_s;

  cdc_sync2 #(.WIDTH(1)) u_ack_sync (
    .clk_in(src_clk_in),
    .nrst_in(src_nrst_in),
    .d_in(d_q.ack),
    .q_out(ack_s)
  );

  cdc_sync2 #(.WIDTH(1)) u_req_sync (
    .clk_in(dst_clk_in),
    .nrst_in(dst_nrst_in),
    .d_in(s_q.req),
    .q_out(req_s)
  );

  // Launch a new word only when the last one was acknowledged; held word stays stable
  always_comb
  begin
    s_d = s_q;
    if ((s_q.req == ack_s) && (src_data_in != s_q.data))
    begin
      s_d.data = src_data_in;
      s_d.req = ~s_q.req;
    end
  end

  // Capture on a request toggle, then answer
  always_comb
  begin
    d_d = d_q;
    if (req_s != d_q.ack)
    begin
      d_d.data = s_q.data;
      d_d.ack = req_s;
    end
  end

  always_ff @(posedge src_clk_in or negedge src_nrst_in)
  begin
    if (!src_nrst_in)
    begin
      s_q <= '{data: RST, req: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge dst_clk_in or negedge dst_nrst_in)
  begin
    if (!dst_nrst_in)
    begin
      d_q <= '{data: RST, ack: 1'b0};
    end
    else
    begin
      d_q <= d_d;
    end
  end

  assign dst_data_out = d_q.data;

endmodule : cdc_word

`default_nettype wire

// ---- verif/ulpi_link_model.sv ----
// Link-side model: ULPI register writes, reads and stop level.
// Assumes the bench resolves the data wire from the PHY drive enable.
`timescale 1ns/1ns
`default_nettype none

module ulpi_link_model (
  input wire logic clk_in, // ULPI clock
  input wire logic nxt_in, // Next from PHY
  input wire logic [7:0] bus_in, // Resolved data wire
  output logic stp_out, // Stop to PHY
  output logic [7:0] data_out // Link drive of data
);
  // Idle bus, stop low
  initial
  begin
    stp_out = 1'b0;
    data_out = 8'h00;
  end

  // Hold the request until next is sampled high, bounded
  task automatic wait_nxt();
    repeat (8)
    begin
      @(posedge clk_in);
      if (nxt_in === 1'b1)
        break;
    end
    #1;
  endtask : wait_nxt

  // Stop left low in the last cycle abandons the write
  task automatic wr(input logic [5:0] a, input logic [7:0] v, input logic go);
    data_out = {2'h2, a};
    wait_nxt();
    data_out = v;
    wait_nxt();
    stp_out = go;
    data_out = 8'h00;
    @(posedge clk_in);
    #1;
    stp_out = 1'b0;
  endtask : wr

  // Turnaround: drive the inverse so a stale copy never passes; left there afterwards,
  // since the inverse of a read command never decodes as a command
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    data_out = {2'h3, a};
    wait_nxt();
    data_out = ~data_out;
    @(posedge clk_in);
    @(posedge clk_in);
    v = bus_in;
    #1;
  endtask : rd

  // Stop held while idle, as a floating pin would be pulled
  task automatic stop(input logic l);
    stp_out = l;
  endtask : stop
endmodule : ulpi_link_model
`default_nettype wire

// ---- verif/ulpi_phy_intf_otg_ctrl_regs_tb.sv ----
// Self-checking bench for the interface and OTG option registers.
// Assumes the link model owns the ULPI side; the bench drives the rest.
`timescale 1ns/1ns
`default_nettype none

module ulpi_phy_intf_otg_ctrl_regs_tb;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic nrst = 1'b0;
  logic fault = 1'b0;
  logic cmp_in = 1'b0;
  logic pwr = 1'b1;
  logic ext = 1'b0;
  logic stp, oe, dir, nxt, pu, pd, fc, bv, ser, cp;
  logic [7:0] ldo, pdo, r, e;
  wire [6:0] otg;
  logic [31:0] seed = 32'h00015388;
  int fails = 0;
  int cmp_count = 0;
  wire [7:0] bus;

  // PHY owns the wire while it drives
  assign bus = oe ? pdo : ldo;

  // Clocks, unrelated in phase
  always #4 core_clk = ~core_clk;
  always
  begin
    #62 link_clk = ~link_clk;
    #63 link_clk = ~link_clk;
  end

  ulpi_phy_intf_otg_ctrl_regs dut (
    .core_clk_in(core_clk), .nrst_in(nrst), .link_clk_in(link_clk), .ulpi_stp_in(stp),
    .ulpi_data_in(bus), .ulpi_data_out(pdo), .ulpi_data_oe_out(oe), .ulpi_dir_out(dir),
    .ulpi_nxt_out(nxt), .stp_weak_pullup_out(pu), .data_weak_pulldown_out(pd),
    .fault_pin_in(fault), .a_dev_bus_valid_cmp_in(cmp_in), .phy_powered_n_lowpower_in(pwr),
    .serial_mode_exit_in(ext), .fault_compl_out(fc), .bus_valid_out(bv),
    .serial_mode_out(ser), .clock_power_out(cp), .ext_supply_drive_out(otg[6]),
    .bus_power_drive_out(otg[5]), .bus_charge_out(otg[4]), .bus_discharge_out(otg[3]),
    .minus_line_pulldown_out(otg[2]), .plus_line_pulldown_out(otg[1]),
    .id_line_pullup_out(otg[0]));

  ulpi_link_model link (.clk_in(link_clk), .nxt_in(nxt), .bus_in(bus), .stp_out(stp),
    .data_out(ldo));

  // Repeatable xorshift source
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  // Expected register after write, set or clear
  function automatic logic [7:0] upd(input logic [7:0] o, d, m, input int k);
    return (k == 0) ? (d & m) : (k == 1) ? (o | (d & m)) : (o & ~d);
  endfunction : upd

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Room for the crossing into the core domain
  task automatic settle();
    repeat (8) @(posedge link_clk);
    #1;
  endtask : settle

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // Watchdog, several times the expected run
  initial
  begin
    #400000;
    fails++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge link_clk);
    #1;
    nrst = 1'b1;
    settle();
    check("pullup", 8'h01, {7'h00, pu});
    check("otg_pins", 8'h06, {1'b0, otg});
    link.rd(6'h0A, r);
    check("otg_reset", 8'h06, r);
    // Random write, set, clear; serial kept off and pass-through kept on
    for (int k = 0; k < 24; k++)
    begin
      logic [7:0] d;
      logic [7:0] m;
      logic [5:0] b;
      b = (k < 12) ? 6'h07 : 6'h0A;
      m = (k < 12) ? 8'hEA : 8'hFF;
      d = (k % 12 == 0) ? 8'hFF : rnd();
      if (k < 12)
        d = (d & 8'hBD) | ((k % 3 == 2) ? 8'h00 : 8'h40);
      link.wr(b + 6'(k % 3), d, 1'b1);
      e = upd(e, d, m, k % 3);
      link.rd(b + 6'((k + 1) % 3), r);
      check("register", e, r);
    end
    settle();
    check("otg_pins", {1'b0, e[6:0]}, {1'b0, otg});
    link.wr(6'h0A, ~e, 1'b0);
    link.rd(6'h0A, r);
    check("dropped", e, r);
    link.rd(6'h3F, r);
    check("unmapped", 8'h00, r);
    // Fault inversion and indicator select, all combinations
    for (int j = 0; j < 16; j++)
    begin
      link.wr(6'h07, {2'h1, j[0], 5'h00}, 1'b1);
      link.wr(j[3] ? 6'h0B : 6'h0C, 8'h80, 1'b1);
      fault = j[1];
      cmp_in = j[2];
      settle();
      check("fault_compl", {7'h00, j[1] ^ j[0]}, {7'h00, fc});
      check("bus_valid", {7'h00, j[3] ? j[1] ^ j[0] : j[2]}, {7'h00, bv});
    end
    // Clock keep against serial mode and power state
    for (int j = 0; j < 8; j++)
    begin
      link.wr(6'h07, {4'h4, j[0], 1'b0, j[1], 1'b0}, 1'b1);
      @(posedge core_clk);
      #1;
      pwr = j[2];
      settle();
      check("serial", {7'h00, j[1]}, {7'h00, ser});
      check("clk_pwr", {7'h00, j[2] & (j[1] ? j[0] : 1'b1)}, {7'h00, cp});
    end
    // Leaving serial mode clears the select bit
    @(posedge core_clk);
    #1;
    ext = 1'b1;
    @(posedge core_clk);
    #1;
    ext = 1'b0;
    settle();
    link.rd(6'h07, r);
    check("self_clear", 8'h48, r);
    // Stop floating high while guard is on, then guard off
    link.stop(1'b1);
    repeat (2) @(posedge link_clk);
    #1;
    check("pulldown", 8'h01, {7'h00, pd});
    link.stop(1'b0);
    link.wr(6'h08, 8'h80, 1'b1);
    // Let the write's own stop release pass an edge first
    @(posedge link_clk);
    #1;
    link.stop(1'b1);
    settle();
    check("guard_off", 8'h00, {6'h00, pu, pd});
    link.stop(1'b0);
    wrap_up();
  end
endmodule : ulpi_phy_intf_otg_ctrl_regs_tb
`default_nettype wire
